// ---- pwa_divider.sv ----
// Signed restoring divider, one quotient bit per cycle, truncating toward zero.
// Assumes start only while idle and a nonzero divisor (caller filters zero).
`timescale 1ns/1ps
module pwa_divider
  import pwa_pkg::*;
#(
  parameter int unsigned W = DWORD_W
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] dividend_i,
  input  wire logic [W-1:0] divisor_i,
  output logic              done_o,
  output logic [W-1:0]      quot_o,
  output logic [W-1:0]      rem_o
);

  localparam int unsigned CW = $clog2(W + 1);

  logic [W-1:0]  q_q, q_d, r_q, r_d, d_q, d_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          neg_q_q, neg_q_d, neg_r_q, neg_r_d;
  logic          busy_q, busy_d, done_d;
  logic [W-1:0]  quot_d, rem_d;
  logic [W:0]    trial;

  function automatic logic [W-1:0] abs_val(input logic [W-1:0] v);
    abs_val = v[W-1] ? (~v + 1'b1) : v;
  endfunction

  // Shift and subtract step
  always_comb begin
    q_d = q_q;
    r_d = r_q;
    d_d = d_q;
    cnt_d = cnt_q;
    neg_q_d = neg_q_q;
    neg_r_d = neg_r_q;
    busy_d = busy_q;
    done_d = 1'b0;
    quot_d = quot_o;
    rem_d = rem_o;
    trial = '0;
    if (start_i && !busy_q) begin
      q_d = abs_val(dividend_i);
      d_d = abs_val(divisor_i);
      r_d = '0;
      cnt_d = CW'(W);
      neg_q_d = dividend_i[W-1] ^ divisor_i[W-1];
      neg_r_d = dividend_i[W-1];
      busy_d = 1'b1;
    end else if (busy_q) begin
      trial = {r_q, q_q[W-1]} - {1'b0, d_q};
      if (!trial[W]) begin
        r_d = trial[W-1:0];
        q_d = {q_q[W-2:0], 1'b1};
      end else begin
        r_d = {r_q[W-2:0], q_q[W-1]};
        q_d = {q_q[W-2:0], 1'b0};
      end
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == CW'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        quot_d = neg_q_q ? (~q_d + 1'b1) : q_d;
        rem_d  = neg_r_q ? (~r_d + 1'b1) : r_d;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q_q <= '0;
      r_q <= '0;
      d_q <= '0;
      cnt_q <= '0;
      neg_q_q <= 1'b0;
      neg_r_q <= 1'b0;
      busy_q <= 1'b0;
      done_o <= 1'b0;
      quot_o <= '0;
      rem_o <= '0;
    end else begin
      q_q <= q_d;
      r_q <= r_d;
      d_q <= d_d;
      cnt_q <= cnt_d;
      neg_q_q <= neg_q_d;
      neg_r_q <= neg_r_d;
      busy_q <= busy_d;
      done_o <= done_d;
      quot_o <= quot_d;
      rem_o <= rem_d;
    end
  end

endmodule

// ---- pwa_edge_mem.sv ----
// Small memory of last-scan condition levels, one bit per instruction slot.
// Assumes one read and one write port on the scan clock; read data registered.
`timescale 1ns/1ps
module pwa_edge_mem
  import pwa_pkg::*;
#(
  parameter int unsigned DEPTH  = 256,
  parameter int unsigned AW     = 8
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic               rd_data_o,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic          wr_data_i
);

  logic [DEPTH-1:0] mem_q;
  logic [DEPTH-1:0] mem_d;
  logic             rd_d;

  // Next contents and read value
  always_comb begin
    mem_d = mem_q;
    if (wr_en_i) begin
      mem_d[wr_addr_i] = wr_data_i;
    end
    rd_d = mem_q[rd_addr_i];
  end

  // Storage, cleared so no false edge after reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_q     <= '0;
      rd_data_o <= 1'b0;
    end else begin
      mem_q     <= mem_d;
      rd_data_o <= rd_d;
    end
  end

endmodule

// ---- pwa_mem_model.sv ----
// Device memory seen from the arithmetic unit: captures every destination word write.
// Assumes writes arrive one word per cycle on the wr_o carrier; addresses wrap at 256.
`timescale 1ns/1ps
module pwa_mem_model
  import pwa_pkg::*;
(
  input  wire logic clk_sys_i,
  input  pwa_wr_type wr_i
);
  logic [WORD_W-1:0] mem [256];
  int unsigned       nwr = 0;

  // Store each written word and count the writes
  always_ff @(posedge clk_sys_i) begin
    if (wr_i.valid === 1'b1) begin
      mem[wr_i.addr[7:0]] <= wr_i.data;
      nwr                 <= nwr + 1;
    end
  end
endmodule

// ---- pwa_pkg.sv ----
// Package for the word arithmetic unit: opcodes, command and result carriers, constants.
// Assumes a single scan clock and a sequencer that issues one command at a time.
package pwa_pkg;

  localparam int unsigned WORD_W       = 16;
  localparam int unsigned DWORD_W      = 32;
  localparam int unsigned QWORD_W      = 64;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned DIGITS_W     = 4;
  localparam int unsigned NIBBLE_W     = 4;
  localparam logic [3:0]  DIGITS_MIN   = 4'h1;
  localparam logic [3:0]  DIGITS_MAX   = 4'h8;
  localparam logic [15:0] FAULT_DIV0   = 16'h1A32; // Decimal 6706
  localparam logic [15:0] FAULT_NONE   = 16'h0000;
  localparam logic [15:0] FAULT_DIGITS = 16'h1A33; // Bad digit count
  localparam logic [2:0]  WORDS_ONE    = 3'h1;
  localparam logic [2:0]  WORDS_TWO    = 3'h2;
  localparam logic [2:0]  WORDS_FOUR   = 3'h4;
  localparam logic [1:0]  IDX_ONE      = 2'h1;
  localparam logic [1:0]  IDX_LAST     = 2'h3;

  typedef enum logic [2:0] {
    PWA_OP_PRODUCT = 3'h0,
    PWA_OP_QUOTIENT = 3'h1,
    PWA_OP_PLUS_ONE = 3'h2,
    PWA_OP_MINUS_ONE = 3'h3,
    PWA_OP_AND = 3'h4,
    PWA_OP_OR = 3'h5
  } pwa_op_type;

  // One command from the scan sequencer
  typedef struct packed {
    pwa_op_type          op;
    logic                wide;      // 1: 32-bit operands
    logic                pulse;     // 1: act on rising edge of cond only
    logic                cond;      // Rung condition this scan
    logic                dst_bits;  // 1: destination is a bit group
    logic [3:0]          digits;    // Bit group width in groups of four
    logic [ADDR_W-1:0]   dst_addr;  // First destination word
    logic [ADDR_W-1:0]   slot;      // Instruction slot for edge memory
    logic [DWORD_W-1:0]  src_a;
    logic [DWORD_W-1:0]  src_b;     // Destination value for plus/minus one
  } pwa_cmd_type;

  // One destination word write to device memory
  typedef struct packed {
    logic                valid;
    logic [ADDR_W-1:0]   addr;
    logic [WORD_W-1:0]   data;
  } pwa_wr_type;

  // Fault report
  typedef struct packed {
    logic                flag;
    logic [WORD_W-1:0]   code;
  } pwa_fault_type;

endpackage

// ---- pwa_word_arith.sv ----
// Word arithmetic unit: multiply, divide, plus/minus one, AND, OR on 16/32-bit words.
// Assumes the scan sequencer holds cmd until done and drains one word write per cycle.
`timescale 1ns/1ps
module pwa_word_arith
  import pwa_pkg::*;
#(
  parameter int unsigned SLOTS   = 256,
  parameter int unsigned SLOT_AW = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         cmd_valid_i,
  input  pwa_cmd_type       cmd_i,
  input  wire logic         fault_clear_i,
  output pwa_wr_type        wr_o,
  output pwa_fault_type     fault_o,
  output logic              busy_o,
  output logic              done_o
);

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_EDGE  = 3'b001,
    ST_EXEC  = 3'b011,
    ST_DIV   = 3'b010,
    ST_WRITE = 3'b110,
    ST_DONE  = 3'b111
  } pwa_state_type;

  pwa_state_type       state_q, state_d;
  logic [QWORD_W-1:0]  res_q, res_d;
  logic [2:0]          nwords_q, nwords_d;
  logic [1:0]          widx_q, widx_d;
  pwa_wr_type          wr_d;
  pwa_fault_type       fault_d;
  logic                done_d;
  logic                busy_d;
  logic                div_start;
  logic                div_done;
  logic [DWORD_W-1:0]  div_quot, div_rem;
  logic [DWORD_W-1:0]  div_a, div_b;
  logic                prev_cond;
  logic                edge_wr;
  logic                fault_set;
  logic [15:0]         fault_code_new;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Sign-extend the operand according to width
  // Sixteen-bit operands carry their sign into the upper half
  function automatic logic [DWORD_W-1:0] sext(input logic [DWORD_W-1:0] v,
                                              input logic wide);
    sext = wide ? v : {{WORD_W{v[WORD_W-1]}}, v[WORD_W-1:0]};
  endfunction

  // Keep only digit count times four low bits
  function automatic logic [DWORD_W-1:0] bit_mask(input logic [3:0] digits);
    logic [DWORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < digits) begin
        m[i*NIBBLE_W +: NIBBLE_W] = 4'hF;
      end
    end
    bit_mask = m;
  endfunction

  // Number of destination words for a result of width w
  function automatic logic [2:0] words_for(input logic wide);
    words_for = wide ? WORDS_TWO : WORDS_ONE;
  endfunction

  // ---------------------------------------------------------------
  // Divider and edge memory
  // ---------------------------------------------------------------
  assign div_a = sext(cmd_i.src_a, cmd_i.wide);
  assign div_b = sext(cmd_i.src_b, cmd_i.wide);

  pwa_divider #(.W(DWORD_W)) u_div (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .start_i    (div_start),
    .dividend_i (div_a),
    .divisor_i  (div_b),
    .done_o     (div_done),
    .quot_o     (div_quot),
    .rem_o      (div_rem)
  );

  pwa_edge_mem #(.DEPTH(SLOTS), .AW(SLOT_AW)) u_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .rd_addr_i (cmd_i.slot[SLOT_AW-1:0]),
    .rd_data_o (prev_cond),
    .wr_en_i   (edge_wr),
    .wr_addr_i (cmd_i.slot[SLOT_AW-1:0]),
    .wr_data_i (cmd_i.cond)
  );

  // ---------------------------------------------------------------
  // Sequencing and result computation
  // ---------------------------------------------------------------
  always_comb begin
    logic [DWORD_W-1:0] a, b, r32;
    logic signed [QWORD_W-1:0] prod;
    logic fire;
    a = sext(cmd_i.src_a, cmd_i.wide);
    b = sext(cmd_i.src_b, cmd_i.wide);
    r32 = '0;
    prod = '0;
    fire = 1'b0;
    state_d = state_q;
    res_d = res_q;
    nwords_d = nwords_q;
    widx_d = widx_q;
    wr_d = '0;
    done_d = 1'b0;
    div_start = 1'b0;
    edge_wr = 1'b0;
    fault_set = 1'b0;
    fault_code_new = FAULT_NONE;
    case (state_q)
      ST_IDLE: begin
        // Hold off while done shows: the sequencer still presents
        // the finished command in the cycle in which it sees done_o
        if (cmd_valid_i && !done_o) begin
          state_d = ST_EDGE;
        end
      end
      ST_EDGE: begin
        // Registered last-scan level is valid now
        // One wait cycle so the slot read has settled
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        // Last-scan level written back every execution, fired or not
        edge_wr = 1'b1;
        fire = cmd_i.pulse ? (cmd_i.cond && !prev_cond) : cmd_i.cond;
        widx_d = '0;
        if (!fire) begin
          state_d = ST_DONE;
        end else if (cmd_i.dst_bits &&
                     (cmd_i.digits < DIGITS_MIN || cmd_i.digits > DIGITS_MAX)) begin
          fault_set = 1'b1;
          fault_code_new = FAULT_DIGITS;
          state_d = ST_DONE;
        end else begin
          state_d = ST_WRITE;
          nwords_d = words_for(cmd_i.wide);
          case (cmd_i.op)
            PWA_OP_PRODUCT: begin
              prod = $signed({{DWORD_W{a[DWORD_W-1]}}, a}) *
                     $signed({{DWORD_W{b[DWORD_W-1]}}, b});
              res_d = prod;
              if (cmd_i.dst_bits) begin
                res_d = {{DWORD_W{1'b0}}, prod[DWORD_W-1:0] & bit_mask(cmd_i.digits)};
                nwords_d = words_for(cmd_i.digits > DIGITS_MAX/2);
              end else begin
                nwords_d = cmd_i.wide ? WORDS_FOUR : WORDS_TWO;
              end
            end
            PWA_OP_QUOTIENT: begin
              if (b == '0) begin
                fault_set = 1'b1;
                fault_code_new = FAULT_DIV0;
                state_d = ST_DONE;
              end else begin
                div_start = 1'b1;
                state_d = ST_DIV;
              end
            end
            PWA_OP_PLUS_ONE: begin
              r32 = b + 32'h0000_0001;
              res_d = {{DWORD_W{1'b0}}, r32};
            end
            PWA_OP_MINUS_ONE: begin
              r32 = b - 32'h0000_0001;
              res_d = {{DWORD_W{1'b0}}, r32};
            end
            PWA_OP_AND: begin
              res_d = {{DWORD_W{1'b0}}, a & b};
            end
            PWA_OP_OR: begin
              res_d = {{DWORD_W{1'b0}}, a | b};
            end
            default: begin
              state_d = ST_DONE;
            end
          endcase
          if (cmd_i.dst_bits && cmd_i.op != PWA_OP_PRODUCT) begin
            res_d = res_d & {{DWORD_W{1'b0}}, bit_mask(cmd_i.digits)};
          end
        end
      end
      ST_DIV: begin
        // Divider outputs are taken on its done pulse
        if (div_done) begin
          state_d = ST_WRITE;
          if (cmd_i.dst_bits) begin
            // Quotient only, no remainder
            res_d = {{DWORD_W{1'b0}}, div_quot & bit_mask(cmd_i.digits)};
            nwords_d = words_for(cmd_i.digits > DIGITS_MAX/2);
          end else if (cmd_i.wide) begin
            res_d = {div_rem, div_quot};
            nwords_d = WORDS_FOUR;
          end else begin
            res_d = {{DWORD_W{1'b0}}, div_rem[WORD_W-1:0], div_quot[WORD_W-1:0]};
            nwords_d = WORDS_TWO;
          end
        end
      end
      ST_WRITE: begin
        // Lowest word first, consecutive addresses
        // Index stops at four words, the longest result there is
        wr_d.valid = 1'b1;
        wr_d.addr = cmd_i.dst_addr + {{(ADDR_W-2){1'b0}}, widx_q};
        wr_d.data = res_q[widx_q*WORD_W +: WORD_W];
        widx_d = widx_q + IDX_ONE;
        if ({1'b0, widx_q} == nwords_q - WORDS_ONE || widx_q == IDX_LAST) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Flag set wins over clear
    // A clear in the cycle of a new fault loses, so no error is missed
    fault_d = fault_o;
    if (fault_clear_i) begin
      fault_d.flag = 1'b0;
    end
    if (fault_set) begin
      fault_d.flag = 1'b1;
      fault_d.code = fault_code_new;
    end
    // Busy follows the next state, so it drops with the done pulse
    busy_d = (state_d != ST_IDLE);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Outputs leave straight from these flip-flops, never from logic
  // fed by the command carrier, so the far side sees no glitch
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q  <= ST_IDLE;
      res_q    <= '0;
      nwords_q <= '0;
      widx_q   <= '0;
      wr_o     <= '0;
      fault_o  <= '0;
      done_o   <= 1'b0;
      busy_o   <= 1'b0;
    end else begin
      state_q  <= state_d;
      res_q    <= res_d;
      nwords_q <= nwords_d;
      widx_q   <= widx_d;
      wr_o     <= wr_d;
      fault_o  <= fault_d;
      done_o   <= done_d;
      busy_o   <= busy_d;
    end
  end

endmodule

// ---- pwa_word_arith_sva.sv ----
// Checker for the word arithmetic unit, bound to its top module ports.
// Assumes one scan clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pwa_word_arith_chk
  import pwa_pkg::*;
(
  input wire logic    clk_sys_i,
  input wire logic    rst_i,
  input wire logic    cmd_valid_i,
  input pwa_cmd_type  cmd_i,
  input wire logic    fault_clear_i,
  input pwa_wr_type   wr_o,
  input pwa_fault_type fault_o,
  input wire logic    busy_o,
  input wire logic    done_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // Helper terms
  // ------------------------------------------------------------
  logic take;
  logic live;
  logic div0;
  assign take = cmd_valid_i && !busy_o && !done_o;
  assign live = take && cmd_i.cond && !cmd_i.pulse && !cmd_i.dst_bits && !cmd_i.wide;
  assign div0 = live && cmd_i.op == PWA_OP_QUOTIENT && cmd_i.src_b[15:0] == 16'h0000;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done_o longer than one cycle");
  a_wr_in_busy: assert property (wr_o.valid |-> busy_o)
    else $error("word write outside a command");
  a_take_busy: assert property (take |=> busy_o)
    else $error("command not taken");
  a_busy_ends_done: assert property ($fell(busy_o) |-> done_o)
    else $error("busy ended without done");
  a_div0_fault: assert property (div0 |-> ##[1:8] (fault_o.flag && fault_o.code == FAULT_DIV0))
    else $error("zero divisor fault missing");
  a_div0_no_write: assert property (div0 |-> (!wr_o.valid) [*8])
    else $error("write after zero divisor");
  a_cond_low_quiet: assert property (take && !cmd_i.cond |-> (!wr_o.valid) [*8])
    else $error("write with condition low");
  a_fault_sticky: assert property (fault_o.flag && !fault_clear_i |=> fault_o.flag)
    else $error("fault flag dropped");
  a_inc_word: assert property (live && cmd_i.op == PWA_OP_PLUS_ONE |-> ##[2:5]
    (wr_o.valid && wr_o.addr == cmd_i.dst_addr && wr_o.data == cmd_i.src_b[15:0] + 16'h0001))
    else $error("plus one word wrong");
  a_and_word: assert property (live && cmd_i.op == PWA_OP_AND |-> ##[2:5]
    (wr_o.valid && wr_o.data == (cmd_i.src_a[15:0] & cmd_i.src_b[15:0])))
    else $error("and word wrong");

  // Main scenarios reached
  c_div0: cover property (div0);
  c_wrap: cover property (wr_o.valid && wr_o.data == 16'h8000);
  c_mul32: cover property (take && cmd_i.op == PWA_OP_PRODUCT && cmd_i.wide);
endmodule

bind pwa_word_arith pwa_word_arith_chk u_chk (
  .clk_sys_i     (clk_sys_i),
  .rst_i         (rst_i),
  .cmd_valid_i   (cmd_valid_i),
  .cmd_i         (cmd_i),
  .fault_clear_i (fault_clear_i),
  .wr_o          (wr_o),
  .fault_o       (fault_o),
  .busy_o        (busy_o),
  .done_o        (done_o)
);

// ---- tb.sv ----
// Self-checking bench for the word arithmetic unit with a device memory model.
// Assumes destination words land in the model; results read from words 16..19.
`timescale 1ns/1ps
module tb;
  import pwa_pkg::*;
  logic          clk_sys_i;
  logic          rst_i;
  logic          cmd_valid_i;
  pwa_cmd_type   cmd_i;
  logic          fault_clear_i;
  pwa_wr_type    wr_o;
  pwa_fault_type fault_o;
  logic          busy_o;
  logic          done_o;
  int            mismatches = 0;
  int            total_checks = 0;
  int unsigned   nw;

  pwa_word_arith uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .fault_clear_i(fault_clear_i), .wr_o(wr_o), .fault_o(fault_o),
    .busy_o(busy_o), .done_o(done_o));
  pwa_mem_model mm (.clk_sys_i(clk_sys_i), .wr_i(wr_o));

  // ------------------------------------------------------------
  // Clock and helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [63:0] w4();
    return {mm.mem[19], mm.mem[18], mm.mem[17], mm.mem[16]};
  endfunction

  // One command; f = {wide, pulse, cond, dst_bits}; destination word 16
  task automatic run(input pwa_op_type op, input logic [3:0] f, input logic [3:0] dg,
                     input logic [31:0] a, input logic [31:0] b);
    int unsigned n;
    n = mm.nwr;
    cmd_i <= '{op:op, wide:f[3], pulse:f[2], cond:f[1], dst_bits:f[0], digits:dg,
               dst_addr:16'h0010, slot:{15'h0000, f[2]}, src_a:a, src_b:b};
    cmd_valid_i <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_sys_i);
      if (done_o === 1'b1) break;
      if (i == 99) mismatches++;
    end
    cmd_valid_i <= 1'b0; // Released at the edge that samples done high
    @(posedge clk_sys_i);
    nw = mm.nwr - n;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_mul();
    run(PWA_OP_PRODUCT, 4'h2, 4'h4, 32'h0000FFFD, 32'h00000007);
    chk(nw, 2);
    chk(w4() & 64'hFFFFFFFF, 64'hFFFFFFEB);
    run(PWA_OP_PRODUCT, 4'hA, 4'h4, 32'hFFFFFFFE, 32'h00000003);
    chk(nw, 4);
    chk(w4(), 64'hFFFFFFFFFFFFFFFA);
    run(PWA_OP_PRODUCT, 4'h3, 4'h4, 32'h00000100, 32'h00000100);
    chk(nw, 1);
    chk(mm.mem[16], 16'h0000);
    run(PWA_OP_PRODUCT, 4'hB, 4'h8, 32'h00010000, 32'h00010003);
    chk(nw, 2);
    chk(w4() & 64'hFFFFFFFF, 64'h00030000);
  endtask

  task automatic t_div();
    run(PWA_OP_QUOTIENT, 4'h2, 4'h4, 32'h0000FFF9, 32'h00000002);
    chk(nw, 2);
    chk({mm.mem[17], mm.mem[16]}, 32'hFFFFFFFD);
    run(PWA_OP_QUOTIENT, 4'hA, 4'h4, 32'h00000064, 32'hFFFFFFF9);
    chk(nw, 4);
    chk(w4(), 64'h00000002FFFFFFF2);
    run(PWA_OP_QUOTIENT, 4'h3, 4'h4, 32'h00000009, 32'h00000002);
    chk(nw, 1);
    chk(mm.mem[16], 16'h0004);
    run(PWA_OP_QUOTIENT, 4'h2, 4'h4, 32'h00000005, 32'h00000000);
    chk(nw, 0);
    chk(mm.mem[16], 16'h0004);
    chk(fault_o, {1'b1, FAULT_DIV0});
    fault_clear_i <= 1'b1;
    @(posedge clk_sys_i);
    fault_clear_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(fault_o.flag, 1'b0);
  endtask

  task automatic t_wrap();
    run(PWA_OP_PLUS_ONE, 4'h2, 4'h4, 32'h0, 32'h00007FFF);
    chk(mm.mem[16], 16'h8000);
    run(PWA_OP_PLUS_ONE, 4'hA, 4'h4, 32'h0, 32'h7FFFFFFF);
    chk({mm.mem[17], mm.mem[16]}, 32'h80000000);
    run(PWA_OP_MINUS_ONE, 4'h2, 4'h4, 32'h0, 32'h00008000);
    chk(mm.mem[16], 16'h7FFF);
    run(PWA_OP_MINUS_ONE, 4'hA, 4'h4, 32'h0, 32'h80000000);
    chk({mm.mem[17], mm.mem[16]}, 32'h7FFFFFFF);
    chk(fault_o.flag, 1'b0);
  endtask

  task automatic t_pulse();
    run(PWA_OP_PLUS_ONE, 4'h6, 4'h4, 32'h0, 32'h00000005);
    chk(nw, 1);
    chk(mm.mem[16], 16'h0006);
    run(PWA_OP_PLUS_ONE, 4'h6, 4'h4, 32'h0, 32'h00000006);
    chk(nw, 0);
    run(PWA_OP_MINUS_ONE, 4'h4, 4'h4, 32'h0, 32'h00000006);
    chk(nw, 0);
    run(PWA_OP_MINUS_ONE, 4'h6, 4'h4, 32'h0, 32'h00000006);
    chk(nw, 1);
    run(PWA_OP_PLUS_ONE, 4'h2, 4'h4, 32'h0, 32'h00000005);
    run(PWA_OP_PLUS_ONE, 4'h2, 4'h4, 32'h0, 32'h00000006);
    chk(nw, 1);
    chk(mm.mem[16], 16'h0007);
  endtask

  task automatic t_logic();
    run(PWA_OP_AND, 4'h2, 4'h4, 32'h0000F0F0, 32'h00003C3C);
    chk(mm.mem[16], 16'h3030);
    run(PWA_OP_OR, 4'hA, 4'h4, 32'hF0000001, 32'h0F000010);
    chk({mm.mem[17], mm.mem[16]}, 32'hFF000011);
    run(PWA_OP_AND, 4'h3, 4'h0, 32'h00000001, 32'h00000001);
    chk(nw, 0);
    chk(fault_o, {1'b1, FAULT_DIGITS});
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    fault_clear_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_mul();
    t_div();
    t_wrap();
    t_pulse();
    t_logic();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    report_and_stop();
  end
endmodule
